/* File: rbuf_pkg.sv */
// constants and carrier types of the read-buffer mode handler
package rbuf_pkg;
    // command block decode
    localparam logic [7:0]  OPC_READ_BUF  = 8'h3c;
    localparam logic [4:0]  MODE_LOG      = 5'h01;
    localparam logic [4:0]  MODE_DATA     = 5'h02;
    localparam logic [4:0]  MODE_DESC     = 5'h03;
    localparam logic [4:0]  MODE_ECHO     = 5'h0a;
    localparam logic [4:0]  MODE_EDESC    = 5'h0b;
    localparam logic [2:0]  LOG_SPEC      = 3'h2;
    localparam logic [7:0]  LOG_SEL       = 8'ha6;
    localparam logic [7:0]  DATA_SEL      = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // telemetry log layout
    localparam logic [23:0] LOG_SIZE      = 24'h01_8000;
    localparam logic [63:0] LOG_SIZE_Q    = 64'h0000_0000_0001_8000;
    localparam logic [63:0] PAGE_SIZE_Q   = 64'h0000_0000_0000_4000;
    localparam logic [63:0] NUM_PAGES     = 64'h0000_0000_0000_0006;
    localparam logic [63:0] REV_MAJOR     = 64'h0000_0000_0000_0002;
    localparam logic [63:0] REV_MINOR     = 64'h0000_0000_0000_0004;
    localparam logic [63:0] REV_SUB       = 64'h0000_0000_0000_0000;
    localparam logic [63:0] MAX_HEADS     = 64'h0000_0000_0000_0018;
    localparam logic [10:0] W_SIG         = 11'h000;
    localparam logic [10:0] W_REV_MAJOR   = 11'h001;
    localparam logic [10:0] W_REV_MINOR   = 11'h002;
    localparam logic [10:0] W_REV_SUB     = 11'h003;
    localparam logic [10:0] W_PAGES       = 11'h004;
    localparam logic [10:0] W_LOG_SIZE    = 11'h005;
    localparam logic [10:0] W_PAGE_SIZE   = 11'h006;
    localparam logic [10:0] W_HEADS       = 11'h007;
    localparam logic [10:0] W_PAGE_NUM    = 11'h000;
    localparam logic [10:0] W_COPY_NUM    = 11'h001;
    localparam int          ST_SUPPORTED  = 7;
    localparam int          ST_VALID      = 6;
    localparam int          ST_LIMITED    = 5;
    ////////////////////////////////////////////////////////////////////////
    // buffers and descriptors
    localparam logic [7:0]  OFS_BOUNDARY  = 8'h09;
    localparam logic [23:0] DBUF_SIZE     = 24'h01_0000;
    localparam logic [23:0] DESC_LEN      = 24'h00_0004;
    localparam logic [12:0] ECHO_CAP      = 13'h00fc;
    localparam int          ECHO_AW       = 8;
    ////////////////////////////////////////////////////////////////////////
    // sense data
    localparam logic [3:0]  SK_ILLEGAL    = 4'h5;
    localparam logic [7:0]  ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0]  ASC_BAD_OPC   = 8'h20;
    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SETTLE_MS     = 1000;
    localparam int          SETTLE_CYC    = SETTLE_MS * (1000000 / CLK_PERIOD_NS);
    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [7:0]  opcode;
        logic [2:0]  mode_spec;
        logic [4:0]  mode;
        logic [7:0]  buffer_selector;
        logic [23:0] offset;
        logic [23:0] alloc_len;
    } cdb_t;
    typedef struct packed {
        logic        supported;
        logic        limited;
        logic        needs_settle;
        logic [55:0] data;
    } field_t;
    typedef struct packed {
        logic        done;
        logic        check;
        logic [3:0]  sense_key;
        logic [7:0]  asc;
    } status_t;
endpackage

/* File: echo_mem.sv */
// echo buffer storage with registered read data
module echo_mem (
    input  wire logic                         clk,
    input  wire logic                         wr_en,
    input  wire logic [rbuf_pkg::ECHO_AW-1:0] wr_addr,
    input  wire logic [7:0]                   wr_data,
    input  wire logic [rbuf_pkg::ECHO_AW-1:0] rd_addr,
    output logic      [7:0]                   rd_data
);
    logic [7:0] mem [0:(1<<rbuf_pkg::ECHO_AW)-1];

    // one write port, one registered read port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // echo_mem

/* File: read_buffer_mode_handler.sv */
// read-buffer command modes: telemetry log, data, descriptors and echo buffer
//
// Contract
// - command block: opcode 3Ch, mode, selector, 3-byte offset, 3-byte allocation length
// - offset zero with length 0x18000 returns the whole 96 KB log
// - telemetry request past the 96 KB end fails with invalid field
// - log is six 16 KiB pages, header page 0, statistics pages 1 to 5
// - header words: signature, revisions 2/4/0, pages, sizes, 24 heads, rest reserved
// - statistics page: page number, copy number, field words, rest reserved
// - field word: status byte on top, seven data bytes below
// - status bit7 supported, bit6 valid, bit5 limited lifetime, bits4-0 zero
// - valid bit of fields that need settling stays clear until the settle time after reset
// - limited fields restart only after one command pulls the whole log
// - data read offset beyond buffer ends with check condition, invalid field
// - data read sends the lesser of allocation length and available data
// - descriptor mode sends up to four bytes; zero length sends nothing
// - descriptor length one to three ends with check condition
// - descriptor byte 0 reports offset boundary 0x09
// - echo read returns last echo write, lesser of request and written
// - echo read ignores top length bytes, selector and offset
// - echo descriptor needs zero offset, sends up to four bytes with capacity
// - echo overwrite supported indication reads zero
module read_buffer_mode_handler #(
    parameter int unsigned SETTLE_CYCLES = rbuf_pkg::SETTLE_CYC,
    parameter logic [63:0] LOG_SIGNATURE = 64'h0123_4567_89ab_cdef // arbitrary value
) (
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         cmd_valid,
    input  wire rbuf_pkg::cdb_t               cmd,
    output logic                              busy,
    output logic                              din_valid,
    output logic [7:0]                        din_byte,
    output logic                              din_last,
    input  wire logic                         din_ready,
    output rbuf_pkg::status_t                 stat,
    output logic [15:0]                       dbuf_addr,
    input  wire logic [7:0]                   dbuf_data,
    output logic [13:0]                       field_addr,
    input  wire rbuf_pkg::field_t             field,
    input  wire logic                         echo_wr_en,
    input  wire logic [rbuf_pkg::ECHO_AW-1:0] echo_wr_addr,
    input  wire logic [7:0]                   echo_wr_data,
    input  wire logic                         echo_wr_commit,
    input  wire logic [7:0]                   echo_wr_len,
    output logic                              limited_restart
);
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_FETCH = 5'b00010,
        S_WAIT1 = 5'b00100,
        S_WAIT2 = 5'b01000,
        S_DONE  = 5'b10000
    } state_t;

    state_t            state_r, state_nxt;
    logic [4:0]        mode_r, mode_nxt;
    logic [23:0]       pos_r, pos_nxt;
    logic [23:0]       end_r, end_nxt;
    logic              whole_r, whole_nxt;
    logic              send_r, send_nxt;
    logic [7:0]        byte_r, byte_nxt;
    logic              last_r, last_nxt;
    rbuf_pkg::status_t stat_r, stat_nxt;
    logic [15:0]       dbuf_addr_r, dbuf_addr_nxt;
    logic [13:0]       field_addr_r, field_addr_nxt;
    logic [7:0]        echo_addr_r, echo_addr_nxt;
    logic              restart_r, restart_nxt;
    logic [15:0]       copy_r, copy_nxt;
    logic [31:0]       settle_r, settle_nxt;
    logic              settled_r, settled_nxt;
    logic              echo_ok_r, echo_ok_nxt;
    logic [7:0]        echo_len_r, echo_len_nxt;
    logic [7:0]        echo_rd_data;
    logic              fld_settle_r;
    logic              busy_r, busy_nxt;

    echo_mem u_echo (
        .clk     (clk),
        .wr_en   (echo_wr_en),
        .wr_addr (echo_wr_addr),
        .wr_data (echo_wr_data),
        .rd_addr (echo_addr_r),
        .rd_data (echo_rd_data)
    );

    // header page word by index
    function automatic logic [63:0] hdr_word(input logic [10:0] w);
        unique case (w)
            rbuf_pkg::W_SIG:       hdr_word = LOG_SIGNATURE;
            rbuf_pkg::W_REV_MAJOR: hdr_word = rbuf_pkg::REV_MAJOR;
            rbuf_pkg::W_REV_MINOR: hdr_word = rbuf_pkg::REV_MINOR;
            rbuf_pkg::W_REV_SUB:   hdr_word = rbuf_pkg::REV_SUB;
            rbuf_pkg::W_PAGES:     hdr_word = rbuf_pkg::NUM_PAGES;
            rbuf_pkg::W_LOG_SIZE:  hdr_word = rbuf_pkg::LOG_SIZE_Q;
            rbuf_pkg::W_PAGE_SIZE: hdr_word = rbuf_pkg::PAGE_SIZE_Q;
            rbuf_pkg::W_HEADS:     hdr_word = rbuf_pkg::MAX_HEADS;
            default:               hdr_word = 64'h0000_0000_0000_0000;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // power-up settle timer and echo-written bookkeeping
    always_comb begin
        settle_nxt   = settle_r;
        settled_nxt  = settled_r;
        echo_ok_nxt  = echo_ok_r;
        echo_len_nxt = echo_len_r;
        if (!settled_r) begin
            settle_nxt  = settle_r + 32'h0000_0001;
            settled_nxt = (settle_r + 32'h0000_0001) >= SETTLE_CYCLES;
        end
        if (echo_wr_commit) begin
            echo_ok_nxt  = 1'b1;
            echo_len_nxt = echo_wr_len;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            settle_r   <= 32'h0000_0000;
            settled_r  <= 1'b0;
            echo_ok_r  <= 1'b0;
            echo_len_r <= 8'h00;
        end else begin
            settle_r   <= settle_nxt;
            settled_r  <= settled_nxt;
            echo_ok_r  <= echo_ok_nxt;
            echo_len_r <= echo_len_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command accept, byte fetch and data-in sequencing
    always_comb begin
        logic [24:0] sum;
        logic [23:0] len;
        logic [23:0] avail;
        logic [63:0] word;
        logic [31:0] dword;
        logic [7:0]  st;
        logic        chk;
        sum            = {1'b0, cmd.offset} + {1'b0, cmd.alloc_len};
        len            = 24'h00_0000;
        avail          = rbuf_pkg::DBUF_SIZE - cmd.offset;
        word           = 64'h0000_0000_0000_0000;
        dword          = 32'h0000_0000;
        st             = 8'h00;
        chk            = 1'b0;
        state_nxt      = state_r;
        mode_nxt       = mode_r;
        pos_nxt        = pos_r;
        end_nxt        = end_r;
        whole_nxt      = whole_r;
        send_nxt       = send_r;
        byte_nxt       = byte_r;
        last_nxt       = last_r;
        stat_nxt       = stat_r;
        stat_nxt.done  = 1'b0;
        dbuf_addr_nxt  = dbuf_addr_r;
        field_addr_nxt = field_addr_r;
        echo_addr_nxt  = echo_addr_r;
        restart_nxt    = 1'b0;
        copy_nxt       = copy_r;
        unique case (state_r)
            S_IDLE: begin
                if (cmd_valid) begin
                    mode_nxt  = cmd.mode;
                    whole_nxt = 1'b0;
                    pos_nxt   = cmd.offset;
                    stat_nxt  = '{1'b0, 1'b0, 4'h0, 8'h00};
                    unique case (cmd.mode)
                        rbuf_pkg::MODE_LOG: begin
                            chk = cmd.mode_spec != rbuf_pkg::LOG_SPEC
                                || cmd.buffer_selector != rbuf_pkg::LOG_SEL
                                || sum > {1'b0, rbuf_pkg::LOG_SIZE};
                            len = cmd.alloc_len;
                            whole_nxt = cmd.offset == 24'h00_0000
                                && cmd.alloc_len == rbuf_pkg::LOG_SIZE;
                        end
                        rbuf_pkg::MODE_DATA: begin
                            chk = cmd.offset >= rbuf_pkg::DBUF_SIZE;
                            len = (cmd.alloc_len < avail) ? cmd.alloc_len : avail;
                        end
                        rbuf_pkg::MODE_DESC: begin
                            chk = cmd.alloc_len != 24'h00_0000
                                && cmd.alloc_len < rbuf_pkg::DESC_LEN;
                            len = (cmd.alloc_len < rbuf_pkg::DESC_LEN)
                                ? cmd.alloc_len : rbuf_pkg::DESC_LEN;
                            pos_nxt = 24'h00_0000;
                        end
                        rbuf_pkg::MODE_ECHO: begin
                            chk = !echo_ok_r;
                            len = {16'h0000, (cmd.alloc_len[7:0] < echo_len_r)
                                ? cmd.alloc_len[7:0] : echo_len_r};
                            pos_nxt = 24'h00_0000;
                        end
                        rbuf_pkg::MODE_EDESC: begin
                            chk = cmd.offset != 24'h00_0000;
                            len = (cmd.alloc_len < rbuf_pkg::DESC_LEN)
                                ? cmd.alloc_len : rbuf_pkg::DESC_LEN;
                            pos_nxt = 24'h00_0000;
                        end
                        default: chk = 1'b1;
                    endcase
                    if (cmd.opcode != rbuf_pkg::OPC_READ_BUF) begin
                        stat_nxt = '{1'b0, 1'b1, rbuf_pkg::SK_ILLEGAL,
                            rbuf_pkg::ASC_BAD_OPC};
                        state_nxt = S_DONE;
                    end else if (chk) begin
                        stat_nxt = '{1'b0, 1'b1, rbuf_pkg::SK_ILLEGAL,
                            rbuf_pkg::ASC_BAD_FIELD};
                        state_nxt = S_DONE;
                    end else if (len == 24'h00_0000) begin
                        state_nxt = S_DONE;
                    end else begin
                        state_nxt = S_FETCH;
                    end
                    end_nxt = pos_nxt + len;
                end
            end
            S_FETCH: begin
                dbuf_addr_nxt  = pos_r[15:0];
                field_addr_nxt = pos_r[16:3];
                echo_addr_nxt  = pos_r[7:0];
                state_nxt      = S_WAIT1;
            end
            S_WAIT1: state_nxt = S_WAIT2;
            S_WAIT2: begin
                if (send_r) begin
                    if (din_ready) begin
                        send_nxt = 1'b0;
                        pos_nxt  = pos_r + 24'h00_0001;
                        state_nxt = last_r ? S_DONE : S_FETCH;
                    end
                end else begin
                    // statistics field word: status byte over seven data bytes
                    st[rbuf_pkg::ST_SUPPORTED] = field.supported;
                    st[rbuf_pkg::ST_VALID] = field.supported
                        && (!field.needs_settle || settled_r);
                    st[rbuf_pkg::ST_LIMITED] = field.supported && field.limited;
                    if (pos_r[16:14] == 3'h0) begin
                        word = hdr_word(pos_r[13:3]);
                    end else if (pos_r[13:3] == rbuf_pkg::W_PAGE_NUM) begin
                        word = {61'h0, pos_r[16:14]};
                    end else if (pos_r[13:3] == rbuf_pkg::W_COPY_NUM) begin
                        word = {48'h0000_0000_0000, copy_r};
                    end else if (field.supported) begin
                        word = {st, field.data};
                    end
                    unique case (mode_r)
                        rbuf_pkg::MODE_DESC: dword = {rbuf_pkg::OFS_BOUNDARY,
                            rbuf_pkg::DBUF_SIZE};
                        rbuf_pkg::MODE_EDESC: dword = {8'h00, 8'h00, 3'h0,
                            rbuf_pkg::ECHO_CAP};
                        default: dword = 32'h0000_0000;
                    endcase
                    unique case (mode_r)
                        rbuf_pkg::MODE_LOG:  byte_nxt = word[{pos_r[2:0], 3'h0} +: 8];
                        rbuf_pkg::MODE_DATA: byte_nxt = dbuf_data;
                        rbuf_pkg::MODE_ECHO: byte_nxt = echo_rd_data;
                        default: byte_nxt = dword[{~pos_r[1:0], 3'h0} +: 8];
                    endcase
                    send_nxt = 1'b1;
                    last_nxt = (pos_r + 24'h00_0001) == end_r;
                end
            end
            S_DONE: begin
                stat_nxt.done = 1'b1;
                last_nxt      = 1'b0;
                if (whole_r && !stat_r.check) begin
                    restart_nxt = 1'b1;
                    copy_nxt    = copy_r + 16'h0001;
                end
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
        busy_nxt = state_nxt != S_IDLE; // busy leaves a flop, in step with the state
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r      <= S_IDLE;
            mode_r       <= 5'h00;
            pos_r        <= 24'h00_0000;
            end_r        <= 24'h00_0000;
            whole_r      <= 1'b0;
            send_r       <= 1'b0;
            byte_r       <= 8'h00;
            last_r       <= 1'b0;
            stat_r       <= '{1'b0, 1'b0, 4'h0, 8'h00};
            dbuf_addr_r  <= 16'h0000;
            field_addr_r <= 14'h0000;
            echo_addr_r  <= 8'h00;
            restart_r    <= 1'b0;
            copy_r       <= 16'h0000;
            fld_settle_r <= 1'b0;
            busy_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            mode_r       <= mode_nxt;
            pos_r        <= pos_nxt;
            end_r        <= end_nxt;
            whole_r      <= whole_nxt;
            send_r       <= send_nxt;
            byte_r       <= byte_nxt;
            last_r       <= last_nxt;
            stat_r       <= stat_nxt;
            dbuf_addr_r  <= dbuf_addr_nxt;
            field_addr_r <= field_addr_nxt;
            echo_addr_r  <= echo_addr_nxt;
            restart_r    <= restart_nxt;
            copy_r       <= copy_nxt;
            fld_settle_r <= (state_r == S_WAIT2 && !send_r) ? field.needs_settle : fld_settle_r;
            busy_r       <= busy_nxt;
        end
    end

    // outputs straight from flops
    assign busy            = busy_r;
    assign din_valid       = send_r;
    assign din_byte        = byte_r;
    assign din_last        = last_r;
    assign stat            = stat_r;
    assign dbuf_addr       = dbuf_addr_r;
    assign field_addr      = field_addr_r;
    assign limited_restart = restart_r;

    ////////////////////////////////////////////////////////////////////////
    // checks on the block's own behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_LOG_END: assert property (
        state_r == S_IDLE && cmd_valid && cmd.opcode == rbuf_pkg::OPC_READ_BUF
        && cmd.mode == rbuf_pkg::MODE_LOG
        && {1'b0, cmd.offset} + {1'b0, cmd.alloc_len} > {1'b0, rbuf_pkg::LOG_SIZE}
        |-> ##2 stat.done && stat.check && stat.asc == rbuf_pkg::ASC_BAD_FIELD)
        else $error("telemetry overrun not refused");
    AST_DATA_OFS: assert property (
        state_r == S_IDLE && cmd_valid && cmd.opcode == rbuf_pkg::OPC_READ_BUF
        && cmd.mode == rbuf_pkg::MODE_DATA && cmd.offset >= rbuf_pkg::DBUF_SIZE
        |-> ##2 stat.done && stat.check && stat.sense_key == rbuf_pkg::SK_ILLEGAL)
        else $error("data offset beyond buffer not refused");
    AST_DESC_SHORT: assert property (
        state_r == S_IDLE && cmd_valid && cmd.opcode == rbuf_pkg::OPC_READ_BUF
        && cmd.mode == rbuf_pkg::MODE_DESC && cmd.alloc_len inside {[1:3]}
        |-> !din_valid ##1 !din_valid ##1 stat.done && stat.check)
        else $error("short descriptor length not refused");
    AST_DESC_BYTE0: assert property (
        din_valid && mode_r == rbuf_pkg::MODE_DESC && pos_r == 24'h00_0000
        |-> din_byte == rbuf_pkg::OFS_BOUNDARY)
        else $error("descriptor boundary byte wrong");
    AST_STATUS_RSVD: assert property (
        din_valid && mode_r == rbuf_pkg::MODE_LOG && pos_r[16:14] != 3'h0
        && pos_r[13:3] > rbuf_pkg::W_COPY_NUM && pos_r[2:0] == 3'h7
        |-> din_byte[4:0] == 5'h00)
        else $error("status reserved bits not zero");
    AST_VALID_SETTLE: assert property (
        din_valid && mode_r == rbuf_pkg::MODE_LOG && pos_r[16:14] != 3'h0
        && pos_r[13:3] > rbuf_pkg::W_COPY_NUM && pos_r[2:0] == 3'h7
        && fld_settle_r && !settled_r |-> !din_byte[rbuf_pkg::ST_VALID])
        else $error("valid bit set before settle time");
    AST_RESTART: assert property (
        limited_restart |-> whole_r && stat.done && !stat.check && $past(state_r) == S_DONE)
        else $error("limited restart without a whole pull");
    AST_LAST_STOP: assert property (
        din_valid && din_last && din_ready |-> ##1 !din_valid ##1 stat.done && !din_valid)
        else $error("data-in did not end after last byte");
    AST_ECHO_UNWRITTEN: assert property (
        state_r == S_IDLE && cmd_valid && cmd.opcode == rbuf_pkg::OPC_READ_BUF
        && cmd.mode == rbuf_pkg::MODE_ECHO && !echo_ok_r |-> ##2 stat.done && stat.check)
        else $error("echo read before echo write not refused");
    AST_EDESC_RSVD: assert property (
        din_valid && mode_r == rbuf_pkg::MODE_EDESC && pos_r[1:0] != 2'h3 && pos_r[1:0] != 2'h2
        |-> din_byte == 8'h00)
        else $error("echo descriptor reserved byte nonzero");
endmodule // read_buffer_mode_handler

/* File: store_model.sv */
// data buffer and field store facing the handler
module store_model (
    input  wire logic        clk,
    input  wire logic [15:0] dbuf_addr,
    output logic      [7:0]  dbuf_data,
    input  wire logic [13:0] field_addr,
    output rbuf_pkg::field_t field
);
    timeunit 1ns;
    timeprecision 1ps;
    // sync read one cycle after the address; odd words limited, words 2 and 3 of 4 need settling
    always_ff @(posedge clk) begin
        dbuf_data <= dbuf_addr[7:0] ^ dbuf_addr[15:8];
        field     <= '{1'b1, field_addr[0], field_addr[1], {42'h0, field_addr}};
    end
endmodule // store_model

/* File: read_buffer_mode_handler_bench.sv */
// self-checking bench of the read-buffer mode handler
module read_buffer_mode_handler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 0, rst = 1, cmd_valid = 0, rdy = 0, busy, din_valid, din_last;
    logic              echo_wr_en = 0, echo_wr_commit = 0, limited_restart;
    logic [7:0]        din_byte, dbuf_data, echo_wr_addr = 0, echo_wr_data = 0, echo_wr_len = 0;
    logic [15:0]       dbuf_addr;
    logic [13:0]       field_addr;
    logic [7:0]        got [0:511];
    int                cnt, mismatches, compares, last_n, restarts;
    rbuf_pkg::cdb_t    cmd = '0;
    rbuf_pkg::status_t stat;
    rbuf_pkg::field_t  field;
    read_buffer_mode_handler #(.SETTLE_CYCLES(1000)) i_dut (.clk, .rst, .cmd_valid, .cmd, .busy,
        .din_valid, .din_byte, .din_last, .din_ready(rdy), .stat, .dbuf_addr, .dbuf_data,
        .field_addr, .field, .echo_wr_en, .echo_wr_addr, .echo_wr_data, .echo_wr_commit,
        .echo_wr_len, .limited_restart);
    store_model i_store (.clk, .dbuf_addr, .dbuf_data, .field_addr, .field);
    // clock and a host that stalls every other cycle
    always #5 clk = ~clk;
    always @(negedge clk) rdy <= ~rdy;
    always @(posedge clk) if (din_valid === 1'b1 && rdy) begin
        got[cnt] <= din_byte;
        cnt <= cnt + 1;
        if (din_last === 1'b1) last_n <= cnt + 1;
    end
    // count restart pulses of limited-lifetime fields
    always @(posedge clk) if (limited_restart === 1'b1) restarts <= restarts + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    function automatic rbuf_pkg::cdb_t mk(logic [4:0] m, logic [2:0] s, logic [7:0] b,
                                          logic [23:0] o, logic [23:0] a);
        return '{rbuf_pkg::OPC_READ_BUF, s, m, b, o, a};
    endfunction
    // one command, bytes counted, end status judged
    task automatic xfer(input rbuf_pkg::cdb_t c, input int n, input logic chk);
        int t;
        @(negedge clk);
        cnt = 0;
        last_n = 0;
        cmd = c;
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
        for (t = 0; t < 4000 && stat.done !== 1'b1; t++) @(negedge clk);
        check(cnt == n && stat.check === chk, "length or status");
        check(!chk || stat.asc === rbuf_pkg::ASC_BAD_FIELD, "sense code");
        check(stat.done === 1'b1 && busy === 1'b0 && last_n == n, "end of command");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_desc;
        xfer(mk(5'h03, 3'h0, 8'h00, 24'h00_0000, 24'h00_0004), 4, 0);
        check(got[0] === 8'h09, "offset boundary");
        xfer(mk(5'h03, 3'h0, 8'h00, 24'h00_0000, 24'h00_0002), 0, 1);
        xfer(mk(5'h03, 3'h0, 8'h00, 24'h00_0000, 24'h00_0000), 0, 0);
        xfer(mk(5'h00, 3'h0, 8'h00, 24'h00_0000, 24'h00_0004), 0, 1);
        $display("descriptor test ended");
    endtask
    task automatic t_data;
        xfer(mk(5'h02, 3'h0, 8'h00, 24'h01_0000, 24'h00_0008), 0, 1);
        xfer(mk(5'h02, 3'h0, 8'h00, 24'h00_fffe, 24'h00_0008), 2, 0);
        check(got[0] === 8'h01, "buffer byte");
        $display("data read test ended");
    endtask
    task automatic t_log;
        xfer(mk(5'h01, 3'h2, 8'ha6, 24'h01_7e00, 24'h00_0400), 0, 1);
        xfer(mk(5'h01, 3'h2, 8'ha6, 24'h00_0000, 24'h00_0200), 512, 0);
        check(got[8] === 8'h02 && got[16] === 8'h04 && got[56] === 8'h18, "revs");
        check(got[41] === 8'h80 && got[42] === 8'h01, "log size");
        xfer(mk(5'h01, 3'h2, 8'ha6, 24'h00_4000, 24'h00_0200), 512, 0);
        check(got[0] === 8'h01 && got[16] === 8'h02, "page word");
        check(got[23] === 8'hc0 && got[31] === 8'he0, "status byte");
        $display("telemetry test ended");
    endtask
    task automatic t_settle;
        @(negedge clk);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        xfer(mk(5'h01, 3'h2, 8'ha6, 24'h00_4000, 24'h00_0200), 512, 0);
        check(got[23] === 8'h80 && got[31] === 8'ha0, "valid before settle");
        check(restarts == 0, "partial pull restarted");
        $display("settle test ended");
    endtask
    task automatic t_echo;
        int i;
        xfer(mk(5'h0a, 3'h0, 8'h00, 24'h00_0000, 24'h00_0004), 0, 1);
        for (i = 0; i < 3; i++) begin
            @(negedge clk);
            {echo_wr_en, echo_wr_addr, echo_wr_data} = {1'b1, i[7:0], 8'ha0 + i[7:0]};
        end
        @(negedge clk);
        {echo_wr_en, echo_wr_commit, echo_wr_len} = {2'b01, 8'h03};
        @(negedge clk);
        echo_wr_commit = 0;
        xfer(mk(5'h0a, 3'h0, 8'h55, 24'h00_0007, 24'hff_0010), 3, 0);
        check(got[2] === 8'ha2, "echo data");
        xfer(mk(5'h0b, 3'h0, 8'h00, 24'h00_0001, 24'h00_0004), 0, 1);
        xfer(mk(5'h0b, 3'h0, 8'h00, 24'h00_0000, 24'h00_0004), 4, 0);
        check({got[0], got[1], got[2], got[3]} === 32'h0000_00fc, "echo desc");
        $display("echo test ended");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("%0d mismatches in %0d compares", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // main sequence after a six-cycle reset
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        t_desc();
        t_data();
        t_log();
        t_settle();
        t_echo();
        print_verdict();
    end
    // watchdog well beyond the expected few thousand cycles
    initial begin
        #300000;
        mismatches++;
        print_verdict();
    end
endmodule // read_buffer_mode_handler_bench
